// *** dv/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       mclk_in,
  input  wire logic       spi_sdo_in,
  output var  logic       spi_sclk_out,
  output var  logic       spi_cs_n_out,
  output var  logic       spi_sdi_out,
  output var  logic [1:0] step_clk_out,
  output var  logic [1:0] step_dir_out,
  output var  logic       rd_valid_out,
  output var  logic [7:0] rd_data_out
);
  // ********
  // host side of serial port and step pins
  // ********
  initial begin
    spi_sclk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_sdi_out  = 1'b0;
    step_clk_out = 2'b00;
    step_dir_out = 2'b00;
    rd_valid_out = 1'b0;
    rd_data_out  = 8'h00;
  end
  // released data line wanders so a stale bit never reads as data
  always @(posedge mclk_in) begin
    if (spi_cs_n_out) begin
      spi_sdi_out <= ~spi_sdi_out;
    end
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // 6 mclk per sclk phase keeps well clear of the pin syncs
  task frame(input logic rd, input logic [14:0] adr, input logic [7:0] dat);
    logic [23:0] sh;
    logic [7:0]  q;
    int          i;
    sh = {rd, adr, dat};
    q  = 8'h00;
    spi_cs_n_out <= 1'b0;
    wait_n(1);
    for (i = 23; i >= 0; i--) begin
      spi_sclk_out <= 1'b0;
      spi_sdi_out  <= sh[i];
      wait_n(6);
      q = {q[6:0], spi_sdo_in};
      spi_sclk_out <= 1'b1;
      wait_n(6);
    end
    spi_sclk_out <= 1'b0;
    wait_n(8);
    spi_cs_n_out <= 1'b1;
    wait_n(6);
    rd_data_out  <= q;
    rd_valid_out <= rd;
    wait_n(1);
    rd_valid_out <= 1'b0;
  endtask
  // flip puts the opposite level on dir before the falling edge
  task step(input int ch, input logic dir, input logic flip);
    step_dir_out[ch] <= dir;
    wait_n(6);
    step_clk_out[ch] <= 1'b1;
    wait_n(6);
    if (flip) begin
      step_dir_out[ch] <= ~dir;
    end
    wait_n(6);
    step_clk_out[ch] <= 1'b0;
    wait_n(8);
  endtask
endmodule
`default_nettype wire

// *** dv/if_chain_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module if_chain_properties
  import if_chain_pkg::*;
(
  input wire logic         mclk_in,
  input wire logic         rst_b_in,
  input wire logic         spi_cs_n_in,
  input wire logic         gain_step_clk_a_in,
  input wire logic         gain_step_clk_b_in,
  input wire logic         spi_sdo_oe_out,
  input wire logic [2:0]   filter_primary_cap_sel_out,
  input wire logic [2:0]   filter_secondary_cap_sel_out,
  input wire logic         series_resistor_bypass_out,
  input wire logic [3:0]   if_main_bias_trim_out,
  input wire logic [3:0]   if_linearizer_trim_out,
  input wire logic         gain_stage_supply_sel_out,
  input wire logic         gain_stage_perf_sel_out,
  input wire atten_split_t atten_a_out,
  input wire atten_split_t atten_b_out
);
  // ********
  // quiet-time counters
  // ********
  logic [1:0] clk_q;
  logic [4:0] idle_a;
  logic [4:0] idle_b;
  logic [4:0] cs_high;
  always_ff @(posedge mclk_in) begin
    clk_q <= {gain_step_clk_b_in, gain_step_clk_a_in};
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || !spi_cs_n_in || gain_step_clk_a_in != clk_q[0]) begin
      idle_a <= 5'h00;
    end else if (idle_a != 5'h1F) begin
      idle_a <= idle_a + 5'h01;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || !spi_cs_n_in || gain_step_clk_b_in != clk_q[1]) begin
      idle_b <= 5'h00;
    end else if (idle_b != 5'h1F) begin
      idle_b <= idle_b + 5'h01;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || !spi_cs_n_in) begin
      cs_high <= 5'h00;
    end else if (cs_high != 5'h1F) begin
      cs_high <= cs_high + 5'h01;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  property p_vgs_cap;
    atten_a_out.vgs_atten <= 4'hC && atten_b_out.vgs_atten <= 4'hC;
  endproperty
  a_vgs_cap: assert property (p_vgs_cap)
    else $error("gain stage share too big");
  property p_split_weight;
    (atten_a_out.step_atten == 5'h00 || atten_a_out.vgs_atten == 4'hC) &&
    (atten_b_out.step_atten == 5'h00 || atten_b_out.vgs_atten == 4'hC);
  endproperty
  a_split_weight: assert property (p_split_weight)
    else $error("attenuator used before gain stage full");
  property p_trim_frame;
    $changed({filter_primary_cap_sel_out, filter_secondary_cap_sel_out,
      series_resistor_bypass_out, if_main_bias_trim_out,
      if_linearizer_trim_out}) |-> !spi_cs_n_in;
  endproperty
  a_trim_frame: assert property (p_trim_frame)
    else $error("trim moved outside a frame");
  property p_sel_frame;
    $changed({gain_stage_supply_sel_out, gain_stage_perf_sel_out})
      |-> !spi_cs_n_in ##1 !spi_cs_n_in;
  endproperty
  a_sel_frame: assert property (p_sel_frame)
    else $error("select moved outside a frame");
  property p_atten_a_cause;
    $changed(atten_a_out) |-> idle_a < 5'h0C;
  endproperty
  a_atten_a_cause: assert property (p_atten_a_cause)
    else $error("channel a moved without cause");
  property p_atten_b_cause;
    $changed(atten_b_out) |-> idle_b < 5'h0C;
  endproperty
  a_atten_b_cause: assert property (p_atten_b_cause)
    else $error("channel b moved without cause");
  property p_oe_frame;
    spi_sdo_oe_out |-> cs_high < 5'h05;
  endproperty
  a_oe_frame: assert property (p_oe_frame)
    else $error("sdo driven outside a frame");
  property p_oe_rise;
    $rose(spi_sdo_oe_out) |-> !spi_cs_n_in && $past(spi_cs_n_in, 8) == 1'b0;
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("sdo enabled early in frame");
  c_step_a: cover property ($changed(atten_a_out) && spi_cs_n_in);
  c_step_b: cover property ($changed(atten_b_out) && spi_cs_n_in);
  c_read: cover property ($rose(spi_sdo_oe_out));
endmodule
bind if_chain_ctrl if_chain_properties u_props (
  .mclk_in, .rst_b_in, .spi_cs_n_in, .gain_step_clk_a_in,
  .gain_step_clk_b_in, .spi_sdo_oe_out, .filter_primary_cap_sel_out,
  .filter_secondary_cap_sel_out, .series_resistor_bypass_out,
  .if_main_bias_trim_out, .if_linearizer_trim_out,
  .gain_stage_supply_sel_out, .gain_stage_perf_sel_out,
  .atten_a_out, .atten_b_out
);
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "if_chain_consts.svh"
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); \
  end \
end
module testbench
  import if_chain_pkg::*;
;
  logic         mclk_in, rst_b_in, spi_sdo_out, spi_sdo_oe_out;
  wire logic    spi_sclk_in, spi_cs_n_in, spi_sdi_in, rd_valid;
  wire logic    gain_step_clk_a_in, gain_step_dir_a_in;
  wire logic    gain_step_clk_b_in, gain_step_dir_b_in;
  wire logic    [7:0] rd_data;
  logic         [2:0] filter_primary_cap_sel_out, filter_secondary_cap_sel_out;
  logic         series_resistor_bypass_out, gain_stage_supply_sel_out;
  logic         gain_stage_perf_sel_out;
  logic         [3:0] if_main_bias_trim_out, if_linearizer_trim_out;
  atten_split_t atten_a_out, atten_b_out;
  int           fail_count  = 0;
  int           checks_done = 0;
  logic [7:0]   exp_q[$];
  logic [7:0]   exp_v;
  logic [7:0]   seed = 8'h2F;
  logic [5:0]   code;
  logic [5:0]   codes[5] = '{6'h00, 6'h0B, 6'h0C, 6'h0D, 6'h2B};
  logic [1:0]   sel;
  // undriven sdo wanders rather than holding a stale bit
  wire logic    sdo_line = spi_sdo_oe_out ? spi_sdo_out : ~spi_sdi_in;

  if_chain_ctrl u_dut (
    .mclk_in, .rst_b_in, .spi_sclk_in, .spi_cs_n_in, .spi_sdi_in,
    .spi_sdo_out, .spi_sdo_oe_out, .gain_step_clk_a_in, .gain_step_dir_a_in,
    .gain_step_clk_b_in, .gain_step_dir_b_in, .filter_primary_cap_sel_out,
    .filter_secondary_cap_sel_out, .series_resistor_bypass_out,
    .if_main_bias_trim_out, .if_linearizer_trim_out,
    .gain_stage_supply_sel_out, .gain_stage_perf_sel_out,
    .atten_a_out, .atten_b_out
  );
  host_model u_host (
    .mclk_in, .spi_sdo_in(sdo_line), .spi_sclk_out(spi_sclk_in),
    .spi_cs_n_out(spi_cs_n_in), .spi_sdi_out(spi_sdi_in),
    .step_clk_out({gain_step_clk_b_in, gain_step_clk_a_in}),
    .step_dir_out({gain_step_dir_b_in, gain_step_dir_a_in}),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data)
  );
  // ********
  // helpers
  // ********
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic atten_split_t split_of(input logic [5:0] c);
    atten_split_t s;
    s.vgs_atten  = (c > 6'h0C) ? 4'hC : c[3:0];
    s.step_atten = (c <= 6'h0C) ? 5'h00 :
                   (c > 6'h2B) ? 5'h1F : 5'(c - 6'h0C);
    return s;
  endfunction
  function automatic logic [5:0] next_code(input logic [5:0] c,
                                           input logic up, input logic [1:0] k);
    logic [6:0] st;
    logic [6:0] b;
    st = 7'h01 << k;
    b  = (c > 6'h2B) ? 7'h2B : {1'b0, c};
    if (up) begin
      return (c == 6'h3F) ? c : ((b + st > 7'h2B) ? 6'h2B : 6'(b + st));
    end
    return (b < st) ? 6'h00 : 6'(b - st);
  endfunction
  task wr(input logic [14:0] a, input logic [7:0] d);
    u_host.frame(1'b0, a, d);
  endtask
  task rd_chk(input logic [14:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.frame(1'b1, a, 8'h00);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    if (rd_valid === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK(rd_data, exp_v)
    end
  end
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (40000) @(posedge mclk_in);
    fail_count++;
    report_and_stop;
  end
  // ********
  // scenarios
  // ********
  initial begin
    rst_b_in = 1'b0;
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    u_host.wait_n(4);
    rd_chk(`OFS_GAIN_CTRL_RESET, 8'h03);
    rd_chk(`OFS_GAIN_STAGE_CONFIG, 8'h01);
    rd_chk(`OFS_ATTEN_READBACK_A, 8'h00);
    rd_chk(15'h0050, 8'h00);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      wr(`OFS_IF_FILTER_TRIM,
         {1'b0, seed[2:0], seed[2:0], seed[7]});
      wr(`OFS_IF_MAIN_BIAS_TRIM, {4'h0, seed[6:3]});
      wr(`OFS_IF_LIN_TRIM, {4'h0, ~seed[3:0]});
      `CHK(filter_primary_cap_sel_out, seed[2:0])
      `CHK(filter_secondary_cap_sel_out, seed[2:0])
      `CHK(series_resistor_bypass_out, seed[7])
      `CHK(if_main_bias_trim_out, seed[6:3])
      `CHK(if_linearizer_trim_out, ~seed[3:0])
      rd_chk(`OFS_IF_LIN_TRIM, {4'h0, ~seed[3:0]});
    end
    wr(`OFS_GAIN_STAGE_CONFIG, 8'h80);
    wr(`OFS_ATTEN_REG_A, 8'h6B);
    `CHK(gain_stage_supply_sel_out, 1'b1)
    `CHK(gain_stage_perf_sel_out, 1'b1)
    foreach (codes[k]) begin
      wr(`OFS_ATTEN_REG_B, {2'b00, codes[k]});
      `CHK(atten_b_out, split_of(codes[k]))
      `CHK(atten_a_out, split_of(6'h2B))
    end
    wr(`OFS_ATTEN_READBACK_A, 8'h00);
    rd_chk(`OFS_ATTEN_READBACK_A, 8'h2B);
    rd_chk(`OFS_ATTEN_READBACK_B, 8'h2B);
    wr(`OFS_GAIN_STAGE_CONFIG, 8'h03);
    `CHK(gain_stage_supply_sel_out, 1'b0)
    wr(`OFS_GAIN_CTRL_RESET, 8'h00);
    wr(`OFS_GAIN_CTRL_RESET, 8'h03);
    code = 6'h3F;
    `CHK(atten_a_out, split_of(code))
    for (int j = 0; j < 14; j++) begin
      sel = (j < 4) ? j[1:0] : 2'b11;
      if (j < 4) begin
        wr(`OFS_GAIN_STAGE_CONFIG, {3'b000, sel, 3'b011});
      end
      u_host.step(0, j >= 8, 1'b0);
      code = next_code(code, j >= 8, sel);
      `CHK(atten_a_out, split_of(code))
    end
    rd_chk(`OFS_ATTEN_READBACK_A, {2'b00, code});
    rd_chk(`OFS_ATTEN_READBACK_B, 8'h3F);
    u_host.step(0, 1'b0, 1'b1);
    `CHK(atten_a_out, split_of(6'h3F))
    wr(`OFS_GAIN_CTRL_RESET, 8'h02);
    u_host.step(1, 1'b0, 1'b0);
    `CHK(atten_b_out, split_of(6'h3F))
    wr(`OFS_GAIN_CTRL_RESET, 8'h03);
    u_host.step(1, 1'b0, 1'b0);
    `CHK(atten_b_out, split_of(6'h23))
    `CHK(atten_a_out, split_of(6'h3F))
    wr(`OFS_GAIN_STAGE_CONFIG, 8'h01);
    wr(`OFS_GAIN_CTRL_RESET, 8'h00);
    wr(`OFS_GAIN_CTRL_RESET, 8'h03);
    u_host.step(0, 1'b0, 1'b0);
    `CHK(atten_a_out, split_of(6'h2B))
    report_and_stop;
  end
endmodule
`default_nettype wire

// *** hdl/gain_channel.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "if_chain_consts.svh"
module gain_channel
  import if_chain_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic       step_clk_in,
  input  wire logic       step_dir_in,
  input  wire logic       updown_mode_in,
  input  wire logic       ctrl_reset_n_in,
  input  wire logic [5:0] reg_code_in,
  input  wire logic [1:0] step_sel_in,
  output var  logic [5:0] atten_code_out,
  output var  atten_split_t split_out
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic       clk_s1;
  logic       clk_s2;
  logic       clk_s3;
  logic       dir_s1;
  logic       dir_s2;
  logic       dir_at_rise;
  logic       rise;
  logic       fall;
  logic [5:0] step;
  logic [5:0] base;
  logic [6:0] sum;
  logic [5:0] next_code;

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dir_s1 <= 1'b0;
      dir_s2 <= 1'b0;
    end else begin
      clk_s1 <= step_clk_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dir_s1 <= step_dir_in;
      dir_s2 <= dir_s1;
    end
  end

  assign rise = clk_s2 & ~clk_s3;
  assign fall = ~clk_s2 & clk_s3;

  // ****************************************
  // step arithmetic
  // ****************************************
  always_comb begin
    step = 6'h01 << step_sel_in;
    base = (atten_code_out > `ATTEN_MAX) ? `ATTEN_MAX : atten_code_out;
    sum  = {1'b0, atten_code_out} + {1'b0, step};
    if (!dir_s2) begin
      // raising gain lowers attenuation, rails at zero
      next_code = (base < step) ? 6'h00 : base - step;
    end else if (atten_code_out > `ATTEN_MAX) begin
      next_code = atten_code_out;
    end else begin
      next_code = (sum > {1'b0, `ATTEN_MAX}) ? `ATTEN_MAX : sum[5:0];
    end
  end

  // ****************************************
  // controller state
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      dir_at_rise <= 1'b0;
    end else if (rise) begin
      dir_at_rise <= dir_s2;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      atten_code_out <= `ATTEN_MIN_GAIN;
    end else if (!ctrl_reset_n_in) begin
      atten_code_out <= `ATTEN_MIN_GAIN;
    end else if (!updown_mode_in) begin
      atten_code_out <= reg_code_in;
    end else if (rise) begin
      atten_code_out <= next_code;
    end else if (fall && (dir_s2 != dir_at_rise)) begin
      atten_code_out <= `ATTEN_MIN_GAIN;
    end
  end

  // ****************************************
  // split onto gain stage and attenuator
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      split_out <= '0;
    end else if (atten_code_out >= `VGS_SPAN) begin
      split_out.vgs_atten <= 4'(`VGS_SPAN);
      // codes above 43 clip the attenuator at full scale
      split_out.step_atten <= (atten_code_out > `ATTEN_MAX) ?
        `STEP_ATTEN_MAX : 5'(atten_code_out - `VGS_SPAN);
    end else begin
      split_out.vgs_atten  <= atten_code_out[3:0];
      split_out.step_atten <= 5'h00;
    end
  end

endmodule
`default_nettype wire

// *** hdl/if_chain_consts.svh ***
`ifndef IF_CHAIN_CONSTS_SVH
`define IF_CHAIN_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_GAIN_CTRL_RESET   15'h0021
`define OFS_ATTEN_READBACK_A  15'h003C
`define OFS_ATTEN_READBACK_B  15'h003D
`define OFS_GAIN_STAGE_CONFIG 15'h0103
`define OFS_ATTEN_REG_A       15'h0104
`define OFS_ATTEN_REG_B       15'h0105
`define OFS_IF_FILTER_TRIM    15'h0300
`define OFS_IF_MAIN_BIAS_TRIM 15'h0301
`define OFS_IF_LIN_TRIM       15'h0302

// ****************************************
// reset values
// ****************************************
`define RST_GAIN_CTRL_RESET   8'h03
`define RST_GAIN_STAGE_CONFIG 8'h01
`define RST_ZERO              8'h00

// ****************************************
// field positions and codes
// ****************************************
`define BIT_SUPPLY_SEL        7
`define BIT_PERF_SEL          6
`define BIT_RST_N_A           1
`define BIT_RST_N_B           0
`define MODE_REGISTER         3'h1
`define MODE_UPDOWN           3'h3
`define ATTEN_MAX             6'h2B
`define ATTEN_MIN_GAIN        6'h3F
`define VGS_SPAN              6'h0C
`define STEP_ATTEN_MAX        5'h1F
`define SPI_INSTR_BITS        5'h10
`define SPI_FRAME_BITS        5'h18

`endif

// *** hdl/if_chain_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "if_chain_consts.svh"
module if_chain_ctrl
  import if_chain_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic       spi_sclk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_sdi_in,
  output var  logic       spi_sdo_out,
  output var  logic       spi_sdo_oe_out,
  input  wire logic       gain_step_clk_a_in,
  input  wire logic       gain_step_dir_a_in,
  input  wire logic       gain_step_clk_b_in,
  input  wire logic       gain_step_dir_b_in,
  output var  logic [2:0] filter_primary_cap_sel_out,
  output var  logic [2:0] filter_secondary_cap_sel_out,
  output var  logic       series_resistor_bypass_out,
  output var  logic [3:0] if_main_bias_trim_out,
  output var  logic [3:0] if_linearizer_trim_out,
  output var  logic       gain_stage_supply_sel_out,
  output var  logic       gain_stage_perf_sel_out,
  output var  atten_split_t atten_a_out,
  output var  atten_split_t atten_b_out
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  gain_controller_reset;
  logic [7:0]  gain_stage_config;
  logic [7:0]  gain_stage_perf_select;
  logic [7:0]  atten_reg_b;
  logic [7:0]  if_filter_trim;
  logic [7:0]  if_main_bias_trim;
  logic [7:0]  if_linearizer_trim;
  logic [5:0]  atten_code_a;
  logic [5:0]  atten_code_b;
  logic        updown_mode;

  // ****************************************
  // serial port pin synchronisers
  // ****************************************
  logic [2:0]  pin_s1;
  logic [2:0]  pin_s2;
  logic        sclk_d;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_n;
  logic        sdi;

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      pin_s1 <= 3'h1;
      pin_s2 <= 3'h1;
      sclk_d <= 1'b0;
    end else begin
      pin_s1 <= {spi_sdi_in, spi_sclk_in, spi_cs_n_in};
      pin_s2 <= pin_s1;
      sclk_d <= pin_s2[1];
    end
  end

  assign cs_n      = pin_s2[0];
  assign sdi       = pin_s2[2];
  assign sclk_rise = ~cs_n & pin_s2[1] & ~sclk_d;
  assign sclk_fall = ~cs_n & ~pin_s2[1] & sclk_d;

  // ****************************************
  // serial frame: 16-bit instruction, 8 data bits
  // ****************************************
  spi_state_t  state;
  logic [4:0]  bit_cnt;
  logic [15:0] instr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  rshift;
  logic        wr_stb;
  logic [4:0]  next_cnt;
  logic [14:0] rd_adr;
  logic [7:0]  wr_word;

  assign next_cnt = bit_cnt + 5'h01;
  // the last bit of a field is still on sdi at the edge that completes it
  assign rd_adr   = {instr[13:0], sdi};
  assign wr_word  = {wdata[6:0], sdi};

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || cs_n) begin
      state   <= SPI_INSTR;
      bit_cnt <= 5'h00;
    end else if (sclk_rise) begin
      bit_cnt <= next_cnt;
      case (state)
        SPI_INSTR: begin
          if (next_cnt == `SPI_INSTR_BITS) begin
            state <= SPI_DATA;
          end
        end
        SPI_DATA: begin
          if (next_cnt == `SPI_FRAME_BITS) begin
            state <= SPI_DONE;
          end
        end
        SPI_DONE: begin
          state <= SPI_DONE;
        end
        default: begin
          state <= SPI_INSTR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      instr <= 16'h0000;
      wdata <= 8'h00;
    end else if (sclk_rise && state == SPI_INSTR) begin
      instr <= {instr[14:0], sdi};
    end else if (sclk_rise && state == SPI_DATA) begin
      wdata <= {wdata[6:0], sdi};
    end
  end

  // write lands after the eighth data bit; extra bits are ignored
  assign wr_stb = sclk_rise && state == SPI_DATA &&
                  next_cnt == `SPI_FRAME_BITS && !instr[15];

  always_comb begin
    case (rd_adr)
      `OFS_GAIN_CTRL_RESET:   rdata = gain_controller_reset;
      `OFS_ATTEN_READBACK_A:  rdata = {2'b00, atten_code_a};
      `OFS_ATTEN_READBACK_B:  rdata = {2'b00, atten_code_b};
      `OFS_GAIN_STAGE_CONFIG: rdata = gain_stage_config;
      `OFS_ATTEN_REG_A:       rdata = gain_stage_perf_select;
      `OFS_ATTEN_REG_B:       rdata = atten_reg_b;
      `OFS_IF_FILTER_TRIM:    rdata = if_filter_trim;
      `OFS_IF_MAIN_BIAS_TRIM: rdata = if_main_bias_trim;
      `OFS_IF_LIN_TRIM:       rdata = if_linearizer_trim;
      default:                rdata = 8'h00;
    endcase
  end

  // read data is captured when the instruction completes and shifted
  // out on falling edges, so the host samples on the next rising edge
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || cs_n) begin
      rshift         <= 8'h00;
      spi_sdo_out    <= 1'b0;
      spi_sdo_oe_out <= 1'b0;
    end else if (sclk_rise && state == SPI_INSTR &&
                 next_cnt == `SPI_INSTR_BITS) begin
      rshift <= rdata;
    end else if (sclk_fall && state == SPI_DATA && instr[15]) begin
      spi_sdo_out    <= rshift[7];
      spi_sdo_oe_out <= 1'b1;
      rshift         <= {rshift[6:0], 1'b0};
    end else if (sclk_fall && state == SPI_DONE) begin
      spi_sdo_oe_out <= 1'b0;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      gain_controller_reset  <= `RST_GAIN_CTRL_RESET;
      gain_stage_config      <= `RST_GAIN_STAGE_CONFIG;
      gain_stage_perf_select <= `RST_ZERO;
      atten_reg_b            <= `RST_ZERO;
      if_filter_trim         <= `RST_ZERO;
      if_main_bias_trim      <= `RST_ZERO;
      if_linearizer_trim     <= `RST_ZERO;
    end else if (wr_stb) begin
      case (instr[14:0])
        `OFS_GAIN_CTRL_RESET:   gain_controller_reset  <= wr_word;
        `OFS_GAIN_STAGE_CONFIG: gain_stage_config      <= wr_word;
        `OFS_ATTEN_REG_A:       gain_stage_perf_select <= wr_word;
        `OFS_ATTEN_REG_B:       atten_reg_b            <= wr_word;
        `OFS_IF_FILTER_TRIM:    if_filter_trim         <= wr_word;
        `OFS_IF_MAIN_BIAS_TRIM: if_main_bias_trim      <= wr_word;
        `OFS_IF_LIN_TRIM:       if_linearizer_trim     <= wr_word;
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // analog control outputs
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      filter_primary_cap_sel_out   <= 3'h0;
      filter_secondary_cap_sel_out <= 3'h0;
      series_resistor_bypass_out   <= 1'b0;
      if_main_bias_trim_out        <= 4'h0;
      if_linearizer_trim_out       <= 4'h0;
      gain_stage_supply_sel_out    <= 1'b0;
      gain_stage_perf_sel_out      <= 1'b0;
    end else begin
      filter_primary_cap_sel_out   <= if_filter_trim[3:1];
      filter_secondary_cap_sel_out <= if_filter_trim[6:4];
      series_resistor_bypass_out   <= if_filter_trim[0];
      if_main_bias_trim_out        <= if_main_bias_trim[3:0];
      if_linearizer_trim_out       <= if_linearizer_trim[3:0];
      gain_stage_supply_sel_out    <=
        gain_stage_config[`BIT_SUPPLY_SEL];
      gain_stage_perf_sel_out      <=
        gain_stage_perf_select[`BIT_PERF_SEL];
    end
  end

  // ****************************************
  // gain controllers, one per channel
  // ****************************************
  // any mode code other than up/down runs from the register
  assign updown_mode =
    gain_stage_config[2:0] == `MODE_UPDOWN;

  gain_channel u_chan_a (
    .mclk_in         (mclk_in),
    .rst_b_in        (rst_b_in),
    .step_clk_in     (gain_step_clk_a_in),
    .step_dir_in     (gain_step_dir_a_in),
    .updown_mode_in  (updown_mode),
    .ctrl_reset_n_in (gain_controller_reset[`BIT_RST_N_A]),
    .reg_code_in     (gain_stage_perf_select[5:0]),
    .step_sel_in     (gain_stage_config[4:3]),
    .atten_code_out  (atten_code_a),
    .split_out       (atten_a_out)
  );

  gain_channel u_chan_b (
    .mclk_in         (mclk_in),
    .rst_b_in        (rst_b_in),
    .step_clk_in     (gain_step_clk_b_in),
    .step_dir_in     (gain_step_dir_b_in),
    .updown_mode_in  (updown_mode),
    .ctrl_reset_n_in (gain_controller_reset[`BIT_RST_N_B]),
    .reg_code_in     (atten_reg_b[5:0]),
    .step_sel_in     (gain_stage_config[4:3]),
    .atten_code_out  (atten_code_b),
    .split_out       (atten_b_out)
  );

endmodule
`default_nettype wire

// *** hdl/if_chain_pkg.sv ***
package if_chain_pkg;

  typedef struct packed {
    logic [3:0] vgs_atten;
    logic [4:0] step_atten;
  } atten_split_t;

  typedef enum logic [1:0] {
    SPI_INSTR = 2'b00,
    SPI_DATA  = 2'b01,
    SPI_DONE  = 2'b10
  } spi_state_t;

endpackage
